// ---- core/stwh_handler.sv ----
// Safety telegram control/status word handler with AHB-Lite registers
// How it works
// RULE1: control bit 0.0 low removes torque; high releases the request.
// RULE2: control bit 0.1 low starts the timed safe stop.
// RULE3: fault buffer acknowledged only on falling edge of control bit 0.7.
// RULE4: acknowledge copies current fault entries into the acknowledged set.
// RULE5: persisting or unacknowledgeable faults stay in the current set.
// RULE6: unsupported control and status bits are ignored and reported zero.
// RULE7: status bit 0.0 is one while torque removal is in effect.
// RULE8: local safe input and stop timer expiry also set torque removed.
// RULE9: status bit 0.1 is one while the timed stop runs.
// RULE10: local safe input starting the timed stop also sets that bit.
// RULE11: status bit 0.7 is one whenever any safety fault is present.
// RULE12: each cycle is watched; watchdog expiry forces the safe state.
// RULE13: a frame is handled and the reply ready well inside 70 ms.
// RULE14: host sets watchdog slightly above summed times, under 30 percent.
// RULE15: watchdog expiry is a communication fault tripping to safe state.
// RULE16: worst delay 120 ms; default watchdog period 250 ms.
// RULE17: telegram 30: two-byte control word and two-byte status word.
// RULE18: current control and status words are mirrored readable.
// RULE19: watchdog expiry sets bit 3 of the safety status byte.
// RULE20: watchdog restarts per valid frame; fault bit holds until acknowledge.
`timescale 1ns/1ns
`include "stwh_defines.svh"

module stwh_handler #(
   parameter int MS_CYCLES = `STWH_MS_CYCLES,
   parameter int FAULT_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire stwh_pkg::stwh_word_type ctrl_word,
   input wire logic frame_valid,
   input wire logic local_torque_req,
   input wire logic local_tstop_req,
   input wire logic [FAULT_W-1:0] fault_raise,
   input wire logic [FAULT_W-1:0] fault_persist,
   input wire logic [FAULT_W-1:0] fault_unackable,
   output stwh_pkg::stwh_word_type status_word,
   output logic [7:0] safety_status_byte,
   output logic torque_off
);

   // ************************************************************
   // Millisecond timebase
   // ************************************************************
   // Watchdog and stop timer both advance once per millisecond tick
   logic [31:0] ms_cnt_ff;
   logic ms_tick;
   assign ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt_ff <= 32'h0;
      end else if (ms_tick) begin
         ms_cnt_ff <= 32'h0;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 32'h1;
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] cfg_ff;
   logic [15:0] stop_delay_ff;
   logic [15:0] wdog_ms;
   logic wdog_en;
   logic [FAULT_W-1:0] fault_ff;
   logic [FAULT_W-1:0] acked_ff;
   logic wdog_fault_ff;
   logic acked_wdog_ff;
   logic [31:0] fault_word;
   logic [31:0] acked_word;
   stwh_pkg::stwh_word_type ctrl_mirror_ff;
   logic addr_phase;
   assign addr_phase = hsel && hready && htrans[1];
   // Zero wait states: every register answers in its data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wdog_en = cfg_ff[0];
   assign wdog_ms = cfg_ff[31:16];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h0;
      end else begin
         wr_pend_ff <= addr_phase && hwrite;
         wr_addr_ff <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // RULE16 default watchdog period
         cfg_ff <= `STWH_CFG_RESET;
         stop_delay_ff <= `STWH_STOP_DELAY_RESET;
      end else if (wr_pend_ff) begin
         if (wr_addr_ff == `STWH_CONFIG_OFS) begin
            cfg_ff <= hwdata;
         end
         if (wr_addr_ff == `STWH_STOP_DELAY_OFS) begin
            stop_delay_ff <= hwdata[15:0];
         end
      end
   end

   // Read data registered in the address phase: zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (addr_phase && !hwrite) begin
         // RULE18 word mirrors
         unique case (haddr)
            `STWH_CTRL_MIRROR_OFS: hrdata <= {16'h0, ctrl_mirror_ff};
            `STWH_STAT_MIRROR_OFS: hrdata <= {16'h0, status_word};
            `STWH_CONFIG_OFS: hrdata <= cfg_ff;
            `STWH_FAULT_OFS: hrdata <= fault_word;
            `STWH_ACKED_OFS: hrdata <= acked_word;
            `STWH_STOP_DELAY_OFS: hrdata <= {16'h0, stop_delay_ff};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   // ************************************************************
   // Control word capture and acknowledge edge
   // ************************************************************
   // Reset low so the first frame after reset cannot fake an acknowledge
   logic ack_prev_ff;
   logic ack_edge;
   // RULE3 falling edge
   assign ack_edge = frame_valid && ack_prev_ff &&
                     !ctrl_word.byte0[`STWH_BIT_ACK];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_prev_ff <= 1'b0;
         ctrl_mirror_ff <= '0;
      end else if (frame_valid) begin
         ack_prev_ff <= ctrl_word.byte0[`STWH_BIT_ACK];
         // RULE6 unsupported bits dropped
         ctrl_mirror_ff <= {8'h0, ctrl_word.byte0[7], 5'h0,
                            ctrl_word.byte0[1:0]};
      end
   end

   // ************************************************************
   // Cycle watchdog
   // ************************************************************
   logic [15:0] wdog_cnt_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdog_cnt_ff <= 16'h0;
      end else if (frame_valid || !wdog_en) begin
         // RULE20 restart on frame
         wdog_cnt_ff <= 16'h0;
      end else if (ms_tick && wdog_cnt_ff != 16'hffff) begin
         wdog_cnt_ff <= wdog_cnt_ff + 16'h1;
      end
   end

   logic wdog_hit;
   // RULE12 cycle supervision
   assign wdog_hit = wdog_en && (wdog_cnt_ff >= wdog_ms);

   // ************************************************************
   // Fault buffer
   // ************************************************************
   // An acknowledge while the link is still dead loses to the set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdog_fault_ff <= 1'b0;
      end else if (wdog_hit) begin
         // RULE15 expiry is a fault; set wins over acknowledge
         wdog_fault_ff <= 1'b1;
      end else if (ack_edge) begin
         wdog_fault_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_ff <= '0;
         acked_ff <= '0;
         acked_wdog_ff <= 1'b0;
      end else if (ack_edge) begin
         // RULE4 shift to acknowledged set
         acked_ff <= fault_ff;
         acked_wdog_ff <= wdog_fault_ff;
         // RULE5 persisting faults reappear
         fault_ff <= (fault_ff & (fault_persist | fault_unackable)) |
                     fault_raise;
      end else begin
         fault_ff <= fault_ff | fault_raise;
      end
   end

   // ************************************************************
   // Fault register words
   // ************************************************************
   // Watchdog fault in the lowest bit, raised faults above it
   always_comb begin
      fault_word = 32'h0;
      fault_word[`STWH_FAULT_WDOG] = wdog_fault_ff;
      fault_word[`STWH_FAULT_SET_LSB +: FAULT_W] = fault_ff;
   end

   always_comb begin
      acked_word = 32'h0;
      acked_word[`STWH_FAULT_WDOG] = acked_wdog_ff;
      acked_word[`STWH_FAULT_SET_LSB +: FAULT_W] = acked_ff;
   end

   // ************************************************************
   // Stop sequencer
   // ************************************************************
   stwh_pkg::stwh_state_type state_ff;
   logic [15:0] stop_cnt_ff;
   logic torque_req;
   logic tstop_req;
   // A torque request cuts a running timed stop short
   // RULE1 zero-active torque request, RULE12 safe state on expiry
   assign torque_req = !ctrl_mirror_ff.byte0[`STWH_BIT_TORQUE] ||
                       local_torque_req || wdog_fault_ff;
   // RULE2 zero-active timed stop
   assign tstop_req = !ctrl_mirror_ff.byte0[`STWH_BIT_TSTOP] ||
                      local_tstop_req;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= stwh_pkg::STWH_OFF;
         stop_cnt_ff <= 16'h0;
      end else begin
         unique case (state_ff)
            stwh_pkg::STWH_RUN: begin
               stop_cnt_ff <= 16'h0;
               if (torque_req) begin
                  state_ff <= stwh_pkg::STWH_OFF;
               end else if (tstop_req) begin
                  state_ff <= stwh_pkg::STWH_TSTOP;
               end
            end
            stwh_pkg::STWH_TSTOP: begin
               if (torque_req || stop_cnt_ff >= stop_delay_ff) begin
                  // RULE8 timer expiry removes torque
                  state_ff <= stwh_pkg::STWH_OFF;
               end else if (ms_tick) begin
                  stop_cnt_ff <= stop_cnt_ff + 16'h1;
               end
            end
            stwh_pkg::STWH_OFF: begin
               stop_cnt_ff <= 16'h0;
               // RULE1 release when request withdrawn
               if (!torque_req && !tstop_req) begin
                  state_ff <= stwh_pkg::STWH_RUN;
               end
            end
            default: state_ff <= stwh_pkg::STWH_OFF;
         endcase
      end
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   stwh_pkg::stwh_flags_type flags;
   // RULE7 RULE8 torque removed
   assign flags.torque_removed = (state_ff == stwh_pkg::STWH_OFF);
   // RULE9 RULE10 timed stop running
   assign flags.timed_stop_active = (state_ff == stwh_pkg::STWH_TSTOP);
   // RULE11 RULE20 fault flag held to acknowledge
   assign flags.fault_present = (|fault_ff) || wdog_fault_ff;
   assign flags.watchdog_expired = wdog_fault_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_word <= '0;
         safety_status_byte <= 8'h0;
         torque_off <= 1'b1;
      end else begin
         // RULE17 RULE6 two-byte word, byte 1 zero
         status_word <= {8'h0, flags.fault_present, 5'h0,
                         flags.timed_stop_active, flags.torque_removed};
         // RULE19 watchdog bit
         safety_status_byte <= 8'(flags.watchdog_expired) <<
                               `STWH_BIT_WDOG;
         // RULE13 reply ready three cycles after frame, far inside 70 ms
         torque_off <= flags.torque_removed;
      end
   end

endmodule

// ---- core/stwh_defines.svh ----
// Offsets, field positions, reset values and timing counts of the telegram handler
`ifndef STWH_DEFINES_SVH
`define STWH_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define STWH_CTRL_MIRROR_OFS 8'h00
`define STWH_STAT_MIRROR_OFS 8'h04
`define STWH_CONFIG_OFS 8'h08
`define STWH_FAULT_OFS 8'h0c
`define STWH_ACKED_OFS 8'h10
`define STWH_STOP_DELAY_OFS 8'h14

// ************************************************************
// Word bit positions (byte 0) and safety status byte watchdog bit
// ************************************************************
`define STWH_BIT_TORQUE 0
`define STWH_BIT_TSTOP 1
`define STWH_BIT_ACK 7
`define STWH_BIT_FAULT 7
`define STWH_BIT_WDOG 3

// ************************************************************
// Fault register fields and reset values
// ************************************************************
`define STWH_CFG_RESET 32'h00fa_0001
`define STWH_FAULT_WDOG 0
`define STWH_FAULT_SET_LSB 1
`define STWH_STOP_DELAY_RESET 16'h03e8

// ************************************************************
// Timing
// ************************************************************
`define STWH_CLK_HZ 125000000
`define STWH_MS_CYCLES (`STWH_CLK_HZ / 1000)
`define STWH_DEV_ACK_MS 70
`define STWH_WORST_DELAY_MS 120
`define STWH_WDOG_MS 250

`endif

// ---- core/stwh_pkg.sv ----
// Types shared by the telegram handler
package stwh_pkg;

   typedef struct packed {
      logic [7:0] byte1;
      logic [7:0] byte0;
   } stwh_word_type;

   typedef struct packed {
      logic torque_removed;
      logic timed_stop_active;
      logic fault_present;
      logic watchdog_expired;
   } stwh_flags_type;

   typedef enum logic [1:0] {
      STWH_RUN = 2'b00,
      STWH_TSTOP = 2'b01,
      STWH_OFF = 2'b10
   } stwh_state_type;

endpackage

// ---- verif/stwh_host_model.sv ----
// Safety host model sending telegram frames at a fixed spacing
`timescale 1ns/1ns
module stwh_host_model #(
   parameter int GAP = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic [7:0] cmd,
   output logic frame_valid,
   output stwh_pkg::stwh_word_type ctrl_word
);
   // ************************************************************
   // Frame generator
   // ************************************************************
   logic [7:0] cnt_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 8'h00;
         frame_valid <= 1'b0;
         ctrl_word <= 16'h0000;
      end else begin
         cnt_ff <= (cnt_ff == 8'(GAP)) ? 8'h00 : cnt_ff + 8'h01;
         frame_valid <= run && cnt_ff == 8'h00;
         if (run && cnt_ff == 8'h00) begin
            ctrl_word <= {8'h00, cmd & 8'h83};
         end else begin
            // Only valid with a frame, so invert it every cycle between frames instead of holding it
            ctrl_word <= ~ctrl_word;
         end
      end
   end
endmodule

// ---- verif/stwh_handler_assertions.sv ----
// Concurrent checks on the telegram handler ports
`timescale 1ns/1ns
module stwh_handler_assertions #(
   parameter int MS_CYCLES = 10,
   parameter int FAULT_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic frame_valid,
   input wire stwh_pkg::stwh_word_type ctrl_word,
   input wire logic local_torque_req,
   input wire logic local_tstop_req,
   input wire logic [FAULT_W-1:0] fault_raise,
   input wire stwh_pkg::stwh_word_type status_word,
   input wire logic [7:0] safety_status_byte,
   input wire logic torque_off
);
   // ************************************************************
   // Helpers and properties
   // ************************************************************
   logic [1:0] up_ff;
   logic [15:0] idle_ff;
   logic [7:0] s;
   assign s = status_word.byte0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_ff <= 2'h0;
         idle_ff <= 16'h0000;
      end else begin
         up_ff <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
         idle_ff <= frame_valid ? 16'h0000 : idle_ff + 16'h0001;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_unused_zero: assert property (
      status_word.byte1 == 8'h00 && s[6:2] == 5'h00)
      else $error("unsupported status bits set");
   chk_torque_pin: assert property (
      up_ff == 2'h3 |-> torque_off == s[0])
      else $error("torque pin and status bit disagree");
   chk_torque_cmd: assert property (
      frame_valid && !ctrl_word.byte0[0] |-> ##[1:4] s[0])
      else $error("torque request not reported");
   chk_tstop_cmd: assert property (
      frame_valid && ctrl_word.byte0[1:0] == 2'h1 |-> ##[1:4] (s[1] || s[0]))
      else $error("timed stop request not reported");
   chk_local_torque: assert property (
      local_torque_req [*5] |-> s[0])
      else $error("local torque request not reported");
   chk_local_tstop: assert property (
      local_tstop_req [*5] |-> s[1] || s[0])
      else $error("local timed stop not reported");
   chk_fault_flag: assert property (
      |fault_raise |-> ##[1:4] s[7])
      else $error("fault flag missing");
   chk_wdog_safe: assert property (
      $rose(safety_status_byte[3]) |-> ##[0:3] (s[0] && s[7]))
      else $error("watchdog expiry without safe state");
   // Assumes a watchdog period of at least four milliseconds
   chk_wdog_idle: assert property (
      $rose(safety_status_byte[3]) |-> idle_ff > 3 * MS_CYCLES)
      else $error("watchdog expired while frames arrive");
   cover property (frame_valid && !ctrl_word.byte0[0]);
   cover property ($rose(safety_status_byte[3]));
   cover property ($rose(s[1]));
endmodule
bind stwh_handler stwh_handler_assertions #(
   .MS_CYCLES(MS_CYCLES), .FAULT_W(FAULT_W)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .frame_valid(frame_valid),
   .ctrl_word(ctrl_word), .local_torque_req(local_torque_req),
   .local_tstop_req(local_tstop_req), .fault_raise(fault_raise),
   .status_word(status_word), .safety_status_byte(safety_status_byte),
   .torque_off(torque_off));

// ---- verif/testbench.sv ----
// Self-checking bench for the telegram handler
`timescale 1ns/1ns
module testbench;
   // ************************************************************
   // Bench
   // ************************************************************
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic run, lt, ls, fv, tq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] haddr, cmd, fr, fp, fu, ssb, r;
   logic [31:0] hwdata, hrdata, d, v, seed;
   stwh_pkg::stwh_word_type cw, sw;
   int failures, checks_done;
   assign hready = hreadyout;
   stwh_handler #(.MS_CYCLES(10)) i_stwh_handler (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ctrl_word(cw), .frame_valid(fv), .local_torque_req(lt),
      .local_tstop_req(ls), .fault_raise(fr), .fault_persist(fp),
      .fault_unackable(fu), .status_word(sw), .safety_status_byte(ssb),
      .torque_off(tq));
   stwh_host_model i_stwh_host_model (.hclk(hclk), .hresetn(hresetn),
      .run(run), .cmd(cmd), .frame_valid(fv), .ctrl_word(cw));
   task automatic test_done;
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         failures++;
         test_done();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      d = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, d);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // Falling edge of the acknowledge bit between two frames
   task automatic ack;
      @(posedge hclk) cmd <= 8'h03;
      wt(12);
      @(posedge hclk) cmd <= 8'h83;
      wt(12);
   endtask
   function automatic logic [7:0] expb(input logic [3:0] k);
      if (!k[0] || k[2]) return 8'h01;
      if (!k[1] || k[3]) return 8'h02;
      return 8'h00;
   endfunction
   function automatic logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      #200000;
      failures++;
      test_done();
   end
   initial begin
      seed = 32'h6dbd66e9;
      failures = 0;
      checks_done = 0;
      {hresetn, hsel, hwrite, run, lt, ls} = 6'h00;
      {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 8'h00, 32'h0};
      {cmd, fr, fp, fu} = 32'h83000000;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      wt(4);
      chk("torque_off", 32'h1, {31'h0, tq});
      rchk(8'h08, 32'h00fa0001);
      rchk(8'h14, 32'h000003e8);
      rchk(8'h20, 32'h0);
      run <= 1'b1;
      bus(1'b1, 8'h08, 32'h00050001);
      bus(1'b1, 8'h14, 32'h00000005);
      rchk(8'h08, 32'h00050001);
      wt(12);
      chk("status", 32'h0, sw);
      rchk(8'h00, 32'h00000083);
      for (int i = 0; i < 16; i++) begin
         @(posedge hclk) cmd <= 8'h83;
         lt <= 1'b0;
         ls <= 1'b0;
         wt(12);
         @(posedge hclk) cmd <= {6'h20, i[1:0]};
         lt <= i[2];
         ls <= i[3];
         wt(12);
         chk("status", {24'h0, expb(i[3:0])}, sw);
         chk("torque", {31'h0, expb(i[3:0]) == 8'h01}, {31'h0, tq});
      end
      @(posedge hclk) cmd <= 8'h83;
      lt <= 1'b0;
      ls <= 1'b0;
      wt(12);
      @(posedge hclk) cmd <= 8'h81;
      wt(12);
      chk("status", 32'h2, sw);
      wt(68);
      chk("status", 32'h1, sw);
      @(posedge hclk) cmd <= 8'h03;
      wt(12);
      v = rnd();
      r = v[7:0] | 8'h01;
      @(posedge hclk) fr <= r;
      fp <= v[15:8] & r;
      fu <= v[23:16] & r;
      @(posedge hclk) fr <= 8'h00;
      @(posedge hclk) cmd <= 8'h83;
      wt(12);
      chk("status", 32'h80, sw);
      rchk(8'h10, 32'h0);
      rchk(8'h0c, {23'h0, r, 1'b0});
      ack();
      rchk(8'h10, {23'h0, r, 1'b0});
      rchk(8'h0c, {23'h0, fp | fu, 1'b0});
      chk("status", {24'h0, |(fp | fu), 7'h0}, sw);
      @(posedge hclk) fp <= 8'h00;
      fu <= 8'h00;
      ack();
      rchk(8'h0c, 32'h0);
      chk("status", 32'h0, sw);
      @(posedge hclk) run <= 1'b0;
      wt(100);
      chk("safety byte", 32'h08, ssb);
      chk("status", 32'h81, sw);
      @(posedge hclk) run <= 1'b1;
      wt(12);
      ack();
      chk("safety byte", 32'h0, ssb);
      chk("status", 32'h0, sw);
      rchk(8'h04, 32'h0);
      rchk(8'h10, 32'h1);
      test_done();
   end
endmodule
